// file: epci_pkg.sv
package epci_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int unsigned EXT_LINES = 3;
	localparam int unsigned GROUPS    = 5;
	localparam int unsigned GROUP_W   = 8;
	localparam int unsigned PIN_W     = 40;

	////////////////////////////////////////////////////////////////////////////////
	// Data-space offsets
	localparam logic [7:0] ADDR_PC_FLAGS  = 8'h3b;
	localparam logic [7:0] ADDR_EXT_FLAGS = 8'h3c;
	localparam logic [7:0] ADDR_PC_EN     = 8'h68;
	localparam logic [7:0] ADDR_MASK0     = 8'h6b;
	localparam logic [7:0] ADDR_MASK1     = 8'h6c;
	localparam logic [7:0] ADDR_MASK2     = 8'h6d;

	// I/O-space view sits below data space by this distance
	localparam logic [7:0] IO_SPACE_OFS   = 8'h20;
	localparam logic [7:0] IO_PC_FLAGS    = ADDR_PC_FLAGS - IO_SPACE_OFS;
	localparam logic [7:0] IO_EXT_FLAGS   = ADDR_EXT_FLAGS - IO_SPACE_OFS;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [2:0] EXT_RESET      = 3'h0;
	localparam logic [4:0] GRP_RESET      = 5'h00;
	localparam logic [39:0] PIN_RESET     = 40'h00_0000_0000;
	localparam logic [2:0] RSV_EXT_ZERO   = 3'h0;
	localparam logic [4:0] RSV_EXT_FILL   = 5'h00;
	localparam logic [2:0] RSV_PC_FILL    = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Sense modes of an external line
	typedef enum logic [1:0] {
		EPCI_SENSE_LOW  = 2'h0,
		EPCI_SENSE_ANY  = 2'h1,
		EPCI_SENSE_FALL = 2'h2,
		EPCI_SENSE_RISE = 2'h3
	} epci_sense_t;

	////////////////////////////////////////////////////////////////////////////////
	// One core access to the I/O or data space
	typedef struct packed {
		logic       io_space;
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} epci_bus_req_t;

endpackage : epci_pkg

// file: epci_irq_flags.sv
`timescale 1ns/1ps

// Contract
// - Edge or change on an external line sets its pending flag.
// - External vector requested only with global enable, line enable and flag set; in low-level mode the low pin stands in for the flag.
// - Vector execution clears the matching external or group flag.
// - Writing one clears a flag; writing zero leaves it.
// - External flag held zero while its line senses low level.
// - Group n enabled only with its enable bit and global enable.
// - Group 4 covers inputs 39:32 with its own vector.
// - Group 3 covers 31:24, group 2 covers 23:16, separate vectors.
// - Group 1 covers inputs 15:8.
// - Group 0 covers inputs 7:0 with a separate vector.
// - Masked change in a group sets that group's flag.
// - Group vector requested only with flag, group enable and global enable.
// - Input contributes only with its mask bit and group enable set.
// - Inputs with cleared mask bit are ignored.
// - Flag registers decode at data offsets and at offsets minus 0x20.
// - Flags, group enables and masks reset to zero.
// - Group enable bits 4..0 sit at bit positions 4..0.
// - Two-bit sense code: low, any change, falling, rising.
// - Pin changes raise a wake indication without a register access.
module epci_irq_flags (
	input  wire logic                                 core_clk,
	input  wire logic                                 arst_n,
	input  wire epci_pkg::epci_bus_req_t              bus_req,
	output logic [7:0]                                bus_rdata,
	input  wire logic                                 global_irq_en,
	input  wire logic [2:0]                           external_line_enables,
	input  wire epci_pkg::epci_sense_t [2:0]          ext_line_sense_select,
	input  wire logic [2:0]                           ext_line_pins,
	input  wire logic [39:0]                          pin_change_input,
	input  wire logic [7:0]                           pin_change_mask_group3,
	input  wire logic [7:0]                           pin_change_mask_group4,
	input  wire logic [2:0]                           ext_vector_ack,
	input  wire logic [4:0]                           group_vector_ack,
	output logic [2:0]                                ext_irq_req,
	output logic [4:0]                                group_irq_req,
	output logic                                      pin_change_wake
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [39:0] pins_prev_r;
	logic [39:0] pins_prev_nxt;
	logic [2:0]  ext_prev_r;
	logic [2:0]  ext_prev_nxt;
	logic        primed_r;
	logic        primed_nxt;

	logic [2:0]  ext_flags_r;
	logic [2:0]  ext_flags_nxt;
	logic [4:0]  pc_flags_r;
	logic [4:0]  pc_flags_nxt;

	logic [4:0]  pc_en_r;
	logic [4:0]  pc_en_nxt;
	logic [7:0]  mask0_r;
	logic [7:0]  mask0_nxt;
	logic [7:0]  mask1_r;
	logic [7:0]  mask1_nxt;
	logic [7:0]  mask2_r;
	logic [7:0]  mask2_nxt;

	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	logic hit_pc_flags;
	logic hit_ext_flags;
	logic hit_pc_en;
	logic hit_mask0;
	logic hit_mask1;
	logic hit_mask2;

	always_comb
	begin
		hit_pc_flags  = 1'b0;
		hit_ext_flags = 1'b0;
		hit_pc_en     = 1'b0;
		hit_mask0     = 1'b0;
		hit_mask1     = 1'b0;
		hit_mask2     = 1'b0;
		if (bus_req.io_space)
		begin
			// Only the flag registers have an I/O-space alias
			if (bus_req.addr == epci_pkg::IO_PC_FLAGS)
				hit_pc_flags = 1'b1;
			else if (bus_req.addr == epci_pkg::IO_EXT_FLAGS)
				hit_ext_flags = 1'b1;
		end
		else if (bus_req.addr == epci_pkg::ADDR_PC_FLAGS)
			hit_pc_flags = 1'b1;
		else if (bus_req.addr == epci_pkg::ADDR_EXT_FLAGS)
			hit_ext_flags = 1'b1;
		else if (bus_req.addr == epci_pkg::ADDR_PC_EN)
			hit_pc_en = 1'b1;
		else if (bus_req.addr == epci_pkg::ADDR_MASK0)
			hit_mask0 = 1'b1;
		else if (bus_req.addr == epci_pkg::ADDR_MASK1)
			hit_mask1 = 1'b1;
		else if (bus_req.addr == epci_pkg::ADDR_MASK2)
			hit_mask2 = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Change detection
	logic [39:0] mask_all;
	logic [39:0] pin_diff;
	logic [4:0]  grp_set_c;
	logic [2:0]  ext_set_c;
	logic [2:0]  ext_level_c;

	// Group order 4..0 maps to inputs 39:32 .. 7:0
	assign mask_all = {pin_change_mask_group4, pin_change_mask_group3,
		mask2_r, mask1_r, mask0_r};
	// First sample after reset is not a change
	assign pin_diff = (pin_change_input ^ pins_prev_r) & {40{primed_r}};

	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : gen_group
			// Mask bit and group enable both gate each input
			assign grp_set_c[g] = pc_en_r[g] &
				(|(pin_diff[g*8 +: 8] & mask_all[g*8 +: 8]));
		end
		for (g = 0; g < 3; g++)
		begin : gen_ext
			always_comb
			begin
				ext_set_c[g]   = 1'b0;
				ext_level_c[g] = 1'b0;
				case (ext_line_sense_select[g])
					epci_pkg::EPCI_SENSE_LOW:
						ext_level_c[g] = 1'b1;
					epci_pkg::EPCI_SENSE_ANY:
						ext_set_c[g] = primed_r & (ext_line_pins[g] ^ ext_prev_r[g]);
					epci_pkg::EPCI_SENSE_FALL:
						ext_set_c[g] = primed_r & ext_prev_r[g] & ~ext_line_pins[g];
					epci_pkg::EPCI_SENSE_RISE:
						ext_set_c[g] = primed_r & ~ext_prev_r[g] & ext_line_pins[g];
					default:
						ext_set_c[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Unregistered so a change is flagged before the next core access
	assign pin_change_wake = |grp_set_c;

	always_comb
	begin
		pins_prev_nxt = pin_change_input;
		ext_prev_nxt  = ext_line_pins;
		primed_nxt    = 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pins_prev_r <= epci_pkg::PIN_RESET;
			ext_prev_r  <= epci_pkg::EXT_RESET;
			primed_r    <= 1'b0;
		end
		else
		begin
			pins_prev_r <= pins_prev_nxt;
			ext_prev_r  <= ext_prev_nxt;
			primed_r    <= primed_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pending flags
	logic [2:0] ext_clr_c;
	logic [4:0] pc_clr_c;

	always_comb
	begin
		ext_clr_c = ext_vector_ack;
		pc_clr_c  = group_vector_ack;
		if (bus_req.wr && hit_ext_flags)
			ext_clr_c = ext_clr_c | bus_req.wdata[2:0];
		if (bus_req.wr && hit_pc_flags)
			pc_clr_c = pc_clr_c | bus_req.wdata[4:0];
		// Set beats a clear landing in the same cycle
		ext_flags_nxt = ((ext_flags_r & ~ext_clr_c) | ext_set_c) & ~ext_level_c;
		pc_flags_nxt  = (pc_flags_r & ~pc_clr_c) | grp_set_c;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ext_flags_r <= epci_pkg::EXT_RESET;
			pc_flags_r  <= epci_pkg::GRP_RESET;
		end
		else
		begin
			ext_flags_r <= ext_flags_nxt;
			pc_flags_r  <= pc_flags_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enables and masks
	always_comb
	begin
		pc_en_nxt = pc_en_r;
		mask0_nxt = mask0_r;
		mask1_nxt = mask1_r;
		mask2_nxt = mask2_r;
		if (bus_req.wr)
		begin
			// Upper bits dropped: reserved
			if (hit_pc_en)
				pc_en_nxt = bus_req.wdata[4:0];
			if (hit_mask0)
				mask0_nxt = bus_req.wdata;
			if (hit_mask1)
				mask1_nxt = bus_req.wdata;
			if (hit_mask2)
				mask2_nxt = bus_req.wdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_en_r <= epci_pkg::GRP_RESET;
			mask0_r <= epci_pkg::REG_RESET;
			mask1_r <= epci_pkg::REG_RESET;
			mask2_r <= epci_pkg::REG_RESET;
		end
		else
		begin
			pc_en_r <= pc_en_nxt;
			mask0_r <= mask0_nxt;
			mask1_r <= mask1_nxt;
			mask2_r <= mask2_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path: data one cycle after the strobe, held until the next read
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (bus_req.rd)
		begin
			if (hit_pc_flags)
				rdata_nxt = {epci_pkg::RSV_PC_FILL, pc_flags_r};
			else if (hit_ext_flags)
				rdata_nxt = {epci_pkg::RSV_EXT_FILL, ext_flags_r};
			else if (hit_pc_en)
				rdata_nxt = {epci_pkg::RSV_PC_FILL, pc_en_r};
			else if (hit_mask0)
				rdata_nxt = mask0_r;
			else if (hit_mask1)
				rdata_nxt = mask1_r;
			else if (hit_mask2)
				rdata_nxt = mask2_r;
			else
				rdata_nxt = epci_pkg::REG_RESET;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_r <= epci_pkg::REG_RESET;
		else
			rdata_r <= rdata_nxt;
	end

	assign bus_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// Vector requests
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			// Level mode requests straight from the low pin, as its flag stays clear
			ext_irq_req[i] = global_irq_en & external_line_enables[i] &
				(ext_level_c[i] ? ~ext_line_pins[i] : ext_flags_r[i]);
		end
		group_irq_req = pc_flags_r & pc_en_r & {5{global_irq_en}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	AST_EXT_SET: assert property (
		(ext_set_c != 3'h0) |=>
			((ext_flags_r & $past(ext_set_c)) == $past(ext_set_c)))
		else $error("external flag not set after edge");

	AST_EXT_REQ: assert property (
		ext_irq_req[0] |-> (global_irq_en && external_line_enables[0]))
		else $error("external request without enables");

	AST_ACK_CLR: assert property (
		(group_vector_ack[0] && !grp_set_c[0]) |=> !pc_flags_r[0])
		else $error("group flag survived vector");

	AST_W1C: assert property (
		(bus_req.wr && hit_ext_flags && bus_req.wdata[1] && !ext_set_c[1]) |=>
			!ext_flags_r[1])
		else $error("write one did not clear");

	AST_W0_KEEP: assert property (
		(bus_req.wr && hit_pc_flags && bus_req.wdata == 8'h00 &&
			group_vector_ack == 5'h00) |=>
			((pc_flags_r & $past(pc_flags_r)) == $past(pc_flags_r)))
		else $error("write zero changed a flag");

	AST_LEVEL_ZERO: assert property (
		(ext_line_sense_select[2] == epci_pkg::EPCI_SENSE_LOW) |=> !ext_flags_r[2])
		else $error("flag set in level mode");

	AST_GRP_REQ: assert property (
		group_irq_req[4] |-> (pc_en_r[4] && global_irq_en && pc_flags_r[4]))
		else $error("group request without enables");

	AST_MASK_IGNORE: assert property (
		(mask_all == 40'h00_0000_0000) |-> (grp_set_c == 5'h00) ##1
			((pc_flags_r & ~$past(pc_flags_r)) == 5'h00))
		else $error("masked input raised a flag");

	AST_IO_ALIAS: assert property (
		(bus_req.rd && bus_req.io_space && bus_req.addr == epci_pkg::IO_PC_FLAGS) |=>
			(bus_rdata == {3'h0, $past(pc_flags_r)}))
		else $error("i/o alias read wrong");

	AST_RSV_ZERO: assert property (
		(bus_req.rd && (hit_ext_flags || hit_pc_en)) |=> (bus_rdata[7:5] == 3'h0))
		else $error("reserved bits not zero");

	AST_GROUP1_MAP: assert property (
		(primed_r && pc_en_r[1] && mask1_r[7] &&
			(pin_change_input[15] != pins_prev_r[15])) |=> pc_flags_r[1])
		else $error("input 15 missed group 1");

	COV_GROUP_REQ: cover property (grp_set_c[0] ##1 group_irq_req[0] ##[1:8] group_vector_ack[0]);
	COV_EXT_EDGE: cover property (ext_set_c[0] ##1 ext_irq_req[0]);
	COV_SET_CLEAR: cover property (grp_set_c[2] && group_vector_ack[2]);
	COV_LEVEL_REQ: cover property (ext_level_c[1] && ext_irq_req[1]);

endmodule : epci_irq_flags

// file: epci_core_model.sv
`timescale 1ns/1ps
module epci_core_model (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       ack_en,
	input  wire logic [2:0] ext_irq_req,
	input  wire logic [4:0] group_irq_req,
	output logic      [2:0] ext_vector_ack,
	output logic      [4:0] group_vector_ack
);
	logic [7:0] req;
	logic [1:0] wait_r;
	assign req = {group_irq_req, ext_irq_req};
	////////////////////////////////////////////////////////////////////////////////
	// Slow core: vectors three edges late, lowest request first
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wait_r <= 2'h0;
			{group_vector_ack, ext_vector_ack} <= 8'h00;
		end
		else
		begin
			{group_vector_ack, ext_vector_ack} <= 8'h00;
			wait_r <= 2'h0;
			if (ack_en && req != 8'h00 && wait_r != 2'h3)
				wait_r <= wait_r + 2'h1;
			// Gap after the pulse: request drops only one edge later
			if (ack_en && req != 8'h00 && wait_r == 2'h2)
				{group_vector_ack, ext_vector_ack} <= req & (~req + 8'h01);
		end
	end
endmodule : epci_core_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                            core_clk;
	logic                            arst_n;
	epci_pkg::epci_bus_req_t         bus_req;
	logic [7:0]                      bus_rdata;
	logic                            global_irq_en;
	logic [2:0]                      external_line_enables;
	epci_pkg::epci_sense_t [2:0]     ext_line_sense_select;
	logic [2:0]                      ext_line_pins;
	logic [39:0]                     pin_change_input;
	logic [7:0]                      pin_change_mask_group3;
	logic [7:0]                      pin_change_mask_group4;
	logic [2:0]                      ext_vector_ack;
	logic [4:0]                      group_vector_ack;
	logic [2:0]                      ext_irq_req;
	logic [4:0]                      group_irq_req;
	logic                            pin_change_wake;
	logic                            ack_en;
	int                              miscompares = 0;
	int                              n_tests = 0;
	int                              cycles = 0;

	epci_irq_flags epci_irq_flags_inst (.core_clk, .arst_n, .bus_req, .bus_rdata,
		.global_irq_en, .external_line_enables, .ext_line_sense_select, .ext_line_pins,
		.pin_change_input, .pin_change_mask_group3, .pin_change_mask_group4,
		.ext_vector_ack, .group_vector_ack, .ext_irq_req, .group_irq_req,
		.pin_change_wake);
	epci_core_model epci_core_model_inst (.core_clk, .arst_n, .ack_en, .ext_irq_req,
		.group_irq_req, .ext_vector_ack, .group_vector_ack);

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus_op(input logic io, input logic [7:0] a, input logic w, input logic [7:0] d);
		@(negedge core_clk);
		bus_req = '{io, a, w, ~w, d};
		@(negedge core_clk);
		bus_req = '0;
	endtask : bus_op

	task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp, input string w);
		bus_op(io, a, 1'b0, 8'h00);
		check(w, bus_rdata, exp);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] regs [6] = '{8'h3b, 8'h3c, 8'h68, 8'h6b, 8'h6c, 8'h6d};
		foreach (regs[i])
			rd(1'b0, regs[i], 8'h00, "reset value");
		rd(1'b1, 8'h1b, 8'h00, "io group flags");
		bus_op(1'b0, 8'h68, 1'b1, 8'hff);
		rd(1'b0, 8'h68, 8'h1f, "group enables");
		bus_op(1'b0, 8'h6c, 1'b1, 8'ha5);
		rd(1'b0, 8'h6c, 8'ha5, "mask1");
		bus_op(1'b0, 8'h6a, 1'b1, 8'hff);
		rd(1'b0, 8'h6a, 8'h00, "unmapped");
		bus_op(1'b0, 8'h3b, 1'b1, 8'hff);
		rd(1'b0, 8'h3b, 8'h00, "group flags");
		bus_op(1'b0, 8'h68, 1'b1, 8'h00);
		bus_op(1'b0, 8'h6c, 1'b1, 8'h00);
	endtask : t_regs

	task automatic pulse(input int p, input logic wk, input logic [4:0] fl, input string w);
		@(negedge core_clk);
		pin_change_input[p] = ~pin_change_input[p];
		#1 check("wake", {7'h0, pin_change_wake}, {7'h0, wk});
		@(negedge core_clk);
		check(w, {3'h0, group_irq_req}, {3'h0, fl & {5{global_irq_en}}});
		rd(1'b0, 8'h3b, {3'h0, fl}, w);
	endtask : pulse

	// Bit 7 of every group: the upper boundary of each input range
	task automatic t_groups();
		for (int g = 0; g < 5; g++)
		begin
			global_irq_en = (g != 2);
			if (g < 3)
				bus_op(1'b0, 8'h6b + 8'(g), 1'b1, 8'h80);
			pin_change_mask_group3 = (g == 3) ? 8'h80 : 8'h00;
			pin_change_mask_group4 = (g == 4) ? 8'h80 : 8'h00;
			bus_op(1'b0, 8'h68, 1'b1, 8'(1 << g));
			pulse(8 * g + 6, 1'b0, 5'h00, "masked pin");
			pulse(8 * g + 7, 1'b1, 5'(1 << g), "group flag");
			bus_op(1'b1, 8'h1b, 1'b1, 8'h1f & ~8'(1 << g));
			rd(1'b1, 8'h1b, 8'(1 << g), "write zero");
			bus_op(1'b1, 8'h1b, 1'b1, 8'(1 << g));
			rd(1'b0, 8'h3b, 8'h00, "write one");
			bus_op(1'b0, 8'h68, 1'b1, 8'h00);
			pulse(8 * g + 7, 1'b0, 5'h00, "disabled group");
			if (g < 3)
				bus_op(1'b0, 8'h6b + 8'(g), 1'b1, 8'h00);
		end
		global_irq_en = 1'b1;
	endtask : t_groups

	task automatic ext_step(input int i, input logic lvl, input logic hit);
		logic [2:0] fl;
		fl = 3'(hit) << i;
		@(negedge core_clk);
		ext_line_pins[i] = lvl;
		@(negedge core_clk);
		check("ext request", {5'h0, ext_irq_req}, {5'h0, fl & external_line_enables});
		rd(1'b0, 8'h3c, {5'h0, fl}, "ext flag");
		bus_op(1'b1, 8'h1c, 1'b1, 8'h07);
	endtask : ext_step

	task automatic t_ext();
		epci_pkg::epci_sense_t md [3] = '{epci_pkg::EPCI_SENSE_ANY,
			epci_pkg::EPCI_SENSE_FALL, epci_pkg::EPCI_SENSE_RISE};
		for (int i = 0; i < 3; i++)
		begin
			external_line_enables = (i == 1) ? 3'h5 : 3'h7;
			for (int m = 0; m < 3; m++)
			begin
				ext_line_sense_select[i] = md[m];
				ext_step(i, 1'b1, m != 1);
				ext_step(i, 1'b0, m != 2);
			end
			external_line_enables = 3'h7;
			ext_line_sense_select[i] = epci_pkg::EPCI_SENSE_LOW;
			@(negedge core_clk);
			check("level request", {5'h0, ext_irq_req}, 8'(1 << i));
			rd(1'b1, 8'h1c, 8'h00, "level flag");
			global_irq_en = 1'b0;
			#1 check("level gated", {5'h0, ext_irq_req}, 8'h00);
			global_irq_en = 1'b1;
			ext_line_pins[i] = 1'b1;
			#1 check("level high", {5'h0, ext_irq_req}, 8'h00);
			@(negedge core_clk);
			ext_line_pins[i] = 1'b0;
			// Let the low level reach the edge detector before change sensing returns
			@(negedge core_clk);
			ext_line_sense_select[i] = epci_pkg::EPCI_SENSE_ANY;
		end
	endtask : t_ext

	// Core vectors both requests in turn; both flags must drop
	task automatic t_ack();
		int n;
		ack_en = 1'b1;
		bus_op(1'b0, 8'h6b, 1'b1, 8'h01);
		bus_op(1'b0, 8'h68, 1'b1, 8'h01);
		@(negedge core_clk);
		pin_change_input[0] = ~pin_change_input[0];
		ext_line_pins[0] = 1'b1;
		@(negedge core_clk);
		check("req before ack", {ext_irq_req, group_irq_req}, 8'h21);
		for (n = 0; n < 20 && {ext_irq_req, group_irq_req} != 8'h00; n++)
			@(negedge core_clk);
		rd(1'b0, 8'h3b, 8'h00, "group flag after ack");
		rd(1'b0, 8'h3c, 8'h00, "ext flag after ack");
		ack_en = 1'b0;
	endtask : t_ack

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		arst_n = 1'b0;
		bus_req = '0;
		global_irq_en = 1'b1;
		external_line_enables = 3'h7;
		ext_line_sense_select = '{default: epci_pkg::EPCI_SENSE_ANY};
		ext_line_pins = 3'h0;
		pin_change_input = 40'h00_0000_0000;
		pin_change_mask_group3 = 8'h00;
		pin_change_mask_group4 = 8'h00;
		ack_en = 1'b0;
		repeat (10) @(negedge core_clk);
		arst_n = 1'b1;
		t_regs();
		t_groups();
		t_ext();
		t_ack();
		end_of_test();
	end
endmodule : testbench
